/* verilog/flash_command_sequencer.sv */
// Flash command sequencer with APB registers
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`include "flash_seq_params.svh"
module flash_command_sequencer #(
  parameter logic [7:0] KEY       = `FS_KEY_DEFAULT,
  parameter logic [5:0] CMD_WP    = `FS_CMD_WP,
  parameter logic [5:0] CMD_EP    = `FS_CMD_EP,
  parameter logic [5:0] CMD_CPB   = `FS_CMD_CPB,
  parameter logic [5:0] CMD_LOCK  = `FS_CMD_LOCK,
  parameter logic [5:0] CMD_UNLK  = `FS_CMD_UNLOCK,
  parameter logic [5:0] CMD_EA    = `FS_CMD_EA,
  parameter logic [5:0] CMD_CHK   = `FS_CMD_CHK
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hsb_idle,
  input  wire logic        pbuf_wr,
  input  wire logic [20:0] pbuf_word_addr,
  input  wire logic [31:0] pbuf_wdata,
  output logic             irq,
  output logic             array_prog_q,
  output logic             array_erase_page_q,
  output logic             array_erase_all_q,
  output logic             volatile_clear_q,
  output logic [9:0]       array_page_q,
  output logic [31:0]      fuses_out_q
);
  flash_seq_pkg::seq_state_t state_q, state_d;
  logic [9:0]  page_number_field_q;
  logic [5:0]  cmd_q;
  logic [15:0] cnt_q;
  logic        ready_flag_q;
  logic        programming_error_flag_q;
  logic        lock_error_flag_q;
  logic        ones_q;
  logic        rdy_ie_q;
  logic        lock_ie_q;
  logic [31:0] fuses;
  logic [31:0] buf_rd;
  logic [`FS_PAGE_W-1:0] rd_idx_q;
  logic [31:0] rdata_d;

  // APB decode, zero wait states
  wire acc        = psel && penable;
  wire wr_acc     = acc && pwrite;
  wire rd_acc     = acc && !pwrite;
  wire hit_cmd    = paddr == `FS_ADDR_CMD;
  wire hit_ctrl   = paddr == `FS_ADDR_CTRL;
  wire hit_status = paddr == `FS_ADDR_STATUS;
  wire hit_fuse   = paddr == `FS_ADDR_FUSE;
  wire mapped     = hit_cmd | hit_ctrl | hit_status | hit_fuse;
  wire cmd_wr     = wr_acc && hit_cmd;
  wire [7:0] wkey = pwdata[31:24];
  wire [5:0] wcmd = pwdata[5:0];
  wire [9:0] wpage = pwdata[17:8];
  wire busy       = state_q != flash_seq_pkg::ST_IDLE;
  wire code_ok    = (wcmd == CMD_WP) || (wcmd == CMD_EP) || (wcmd == CMD_CPB) ||
                    (wcmd == CMD_LOCK) || (wcmd == CMD_UNLK) ||
                    (wcmd == CMD_EA) || (wcmd == CMD_CHK);
  wire bad_cmd    = cmd_wr && ((wkey != KEY) || !code_ok);
  wire busy_cmd   = cmd_wr && busy;
  wire cmd_accept = cmd_wr && !bad_cmd && !busy;
  wire status_rd  = rd_acc && hit_status;

  // Protection checks
  wire [2:0] boot_size = fuses[`FS_BOOT_LSB+2:`FS_BOOT_LSB];
  wire [3:0] region    = page_number_field_q[`FS_REGION_SHIFT+3:`FS_REGION_SHIFT];
  wire region_locked   = !fuses[region];
  wire [7:0] boot_pages = (boot_size == `FS_BOOT_NONE) ? 8'h00 :
                          8'(8'h80 >> boot_size);
  wire in_boot   = {2'b00, boot_pages} > page_number_field_q;
  wire page_cmd  = (cmd_q == CMD_WP) || (cmd_q == CMD_EP);
  wire page_deny = page_cmd && (region_locked || in_boot);
  wire ea_deny   = (cmd_q == CMD_EA) &&
                   ((fuses[15:0] != 16'hFFFF) || (boot_size != `FS_BOOT_NONE));
  wire deny      = page_deny || ea_deny;
  wire done      = state_q == flash_seq_pkg::ST_DONE;
  wire cnt_end   = cnt_q == 16'd0;
  wire op_start  = (state_q == flash_seq_pkg::ST_WAIT) && hsb_idle && !deny;
  wire deny_hit  = (state_q == flash_seq_pkg::ST_WAIT) && hsb_idle && deny;
  wire ea_run    = cmd_q == CMD_EA;
  wire fuse_lock = op_start && (cmd_q == CMD_LOCK);
  wire fuse_unlk = op_start && (cmd_q == CMD_UNLK);
  wire fuse_ea   = (state_q == flash_seq_pkg::ST_BUSY) && ea_run && cnt_end;
  wire buf_clear = op_start && (cmd_q == CMD_CPB);

  always_comb begin
    state_d = state_q;
    case (state_q)
      flash_seq_pkg::ST_IDLE: if (cmd_accept) state_d = flash_seq_pkg::ST_WAIT;
      flash_seq_pkg::ST_WAIT: begin
        if (deny_hit) state_d = flash_seq_pkg::ST_DONE;
        else if (op_start && ea_run) state_d = flash_seq_pkg::ST_CLEAR;
        else if (op_start) state_d = flash_seq_pkg::ST_BUSY;
      end
      flash_seq_pkg::ST_CLEAR: if (cnt_end) state_d = flash_seq_pkg::ST_BUSY;
      flash_seq_pkg::ST_BUSY: if (cnt_end) state_d = flash_seq_pkg::ST_DONE;
      flash_seq_pkg::ST_DONE: state_d = flash_seq_pkg::ST_IDLE;
      default: state_d = flash_seq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_q <= flash_seq_pkg::ST_IDLE;
    else state_q <= state_d;
  end

  // Operation counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 16'd0;
    else if (op_start && ea_run) cnt_q <= `FS_CLR_CYCLES;
    else if (op_start) cnt_q <= (cmd_q == CMD_CHK) ? 16'(1 << `FS_PAGE_W) : `FS_OP_CYCLES;
    else if ((state_q == flash_seq_pkg::ST_CLEAR) && cnt_end) cnt_q <= `FS_OP_CYCLES;
    else if (!cnt_end) cnt_q <= cnt_q - 16'd1;
  end

  // Latched command and page number
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cmd_q <= 6'h00;
    else if (cmd_accept) cmd_q <= wcmd;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) page_number_field_q <= 10'h000;
    else if (cmd_accept) page_number_field_q <= wpage;
    else if (pbuf_wr) page_number_field_q <= pbuf_word_addr[`FS_PAGE_W+9:`FS_PAGE_W];
  end

  // Status flags; error flags: set wins over read clear, ready flag cleared by an accepted command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ready_flag_q <= 1'b1;
    else if (cmd_accept) ready_flag_q <= 1'b0;
    else if (done) ready_flag_q <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) programming_error_flag_q <= 1'b0;
    else if (bad_cmd || busy_cmd) programming_error_flag_q <= 1'b1;
    else if (status_rd) programming_error_flag_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lock_error_flag_q <= 1'b0;
    else if (deny_hit) lock_error_flag_q <= 1'b1;
    else if (status_rd) lock_error_flag_q <= 1'b0;
  end

  // All-ones page check over buffer words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rd_idx_q <= '0;
    else if (op_start) rd_idx_q <= '0;
    else if (state_q == flash_seq_pkg::ST_BUSY) rd_idx_q <= rd_idx_q + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ones_q <= 1'b1;
    else if (op_start && (cmd_q == CMD_CHK)) ones_q <= 1'b1;
    else if ((state_q == flash_seq_pkg::ST_BUSY) && (cmd_q == CMD_CHK) && !cnt_end)
      ones_q <= ones_q & (&buf_rd);
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_ie_q <= 1'b0;
      lock_ie_q <= 1'b0;
    end else if (wr_acc && hit_ctrl) begin
      rdy_ie_q <= pwdata[0];
      lock_ie_q <= pwdata[2];
    end
  end

  // Interrupt pulses on events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else irq <= (done && rdy_ie_q && (cmd_q != CMD_CHK)) ||
                (deny_hit && lock_ie_q);
  end

  // Array strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      array_prog_q <= 1'b0;
      array_erase_page_q <= 1'b0;
      array_erase_all_q <= 1'b0;
      volatile_clear_q <= 1'b0;
      array_page_q <= 10'h000;
    end else begin
      array_prog_q <= op_start && (cmd_q == CMD_WP);
      array_erase_page_q <= op_start && (cmd_q == CMD_EP);
      array_erase_all_q <= fuse_ea;
      volatile_clear_q <= state_q == flash_seq_pkg::ST_CLEAR;
      array_page_q <= page_number_field_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fuses_out_q <= `FS_FUSE_RESET;
    else fuses_out_q <= fuses;
  end

  // Read data and APB answer
  always_comb begin
    rdata_d = 32'h0;
    if (hit_cmd) rdata_d = {14'h0, page_number_field_q, 2'b00, cmd_q};
    else if (hit_ctrl) rdata_d = {29'h0, lock_ie_q, 1'b0, rdy_ie_q};
    else if (hit_status) rdata_d = {26'h0, ones_q, 1'b0, programming_error_flag_q,
                                    lock_error_flag_q, 1'b0, ready_flag_q};
    else if (hit_fuse) rdata_d = fuses;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (psel && !penable && !pwrite) prdata <= rdata_d;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

  flash_page_buffer u_buf (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (buf_clear),
    .wr_en   (pbuf_wr),
    .wr_idx  (pbuf_word_addr[`FS_PAGE_W-1:0]),
    .wr_data (pbuf_wdata),
    .rd_idx  (rd_idx_q),
    .rd_data (buf_rd)
  );

  flash_fuses u_fuses (
    .pclk      (pclk),
    .presetn   (presetn),
    .set_lock  (fuse_lock),
    .clr_lock  (fuse_unlk),
    .erase_all (fuse_ea),
    .region    (region),
    .fuses_q   (fuses)
  );
endmodule // flash_command_sequencer

/* verilog/flash_seq_params.svh */
// Constants of the flash command sequencer
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH
`define FS_ADDR_CMD        12'h000
`define FS_ADDR_CTRL       12'h004
`define FS_ADDR_STATUS     12'h008
`define FS_ADDR_FUSE       12'h00C
`define FS_KEY_DEFAULT     8'hA5
`define FS_CMD_WP          6'h01
`define FS_CMD_EP          6'h02
`define FS_CMD_CPB         6'h03
`define FS_CMD_LOCK        6'h04
`define FS_CMD_UNLOCK      6'h05
`define FS_CMD_EA          6'h06
`define FS_CMD_CHK         6'h07
`define FS_PAGES           10'd512
`define FS_PAGE_W          7
`define FS_REGION_SHIFT    5
`define FS_FUSE_RESET      32'hFFFFFFFF
`define FS_BOOT_LSB        17
`define FS_BOOT_NONE       3'h7
`define FS_OP_CYCLES       16'd64
`define FS_CLR_CYCLES      16'd8
`define FS_WORD_ONES       32'hFFFFFFFF
`endif

/* verilog/flash_seq_pkg.sv */
// Types of the flash command sequencer
package flash_seq_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_WAIT  = 5'b00010,
    ST_CLEAR = 5'b00100,
    ST_BUSY  = 5'b01000,
    ST_DONE  = 5'b10000
  } seq_state_t;
endpackage

/* verilog/flash_page_buffer.sv */
// Page buffer, writes only clear bits
`timescale 1ns/1ps
`include "flash_seq_params.svh"
module flash_page_buffer (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  clear,
  input  wire logic                  wr_en,
  input  wire logic [`FS_PAGE_W-1:0] wr_idx,
  input  wire logic [31:0]           wr_data,
  input  wire logic [`FS_PAGE_W-1:0] rd_idx,
  output logic      [31:0]           rd_data
);
  logic [31:0] mem_q [0:(1<<`FS_PAGE_W)-1];
  assign rd_data = mem_q[rd_idx];
  genvar i;
  generate
    for (i = 0; i < (1<<`FS_PAGE_W); i++) begin : g_word
      wire sel = wr_en && (wr_idx == `FS_PAGE_W'(i));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) mem_q[i] <= `FS_WORD_ONES;
        else if (clear) mem_q[i] <= `FS_WORD_ONES;
        else if (sel) mem_q[i] <= mem_q[i] & wr_data;
      end
    end
  endgenerate
endmodule // flash_page_buffer

/* verilog/flash_fuses.sv */
// General-purpose fuse bits holding region locks and boot size
`timescale 1ns/1ps
`include "flash_seq_params.svh"
module flash_fuses (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        set_lock,
  input  wire logic        clr_lock,
  input  wire logic        erase_all,
  input  wire logic [3:0]  region,
  output logic      [31:0] fuses_q
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fuses_q <= `FS_FUSE_RESET;
    else if (erase_all) fuses_q <= `FS_FUSE_RESET;
    else if (set_lock) fuses_q[region] <= 1'b0;
    else if (clr_lock) fuses_q[region] <= 1'b1;
  end
endmodule // flash_fuses

/* sim/flash_command_sequencer_props.sv */
// Port checker for the flash command sequencer
`timescale 1ns/1ps
module flash_seq_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        array_prog_q,
  input wire logic        array_erase_page_q,
  input wire logic        array_erase_all_q,
  input wire logic        volatile_clear_q,
  input wire logic [9:0]  array_page_q,
  input wire logic [31:0] fuses_out_q
);
  logic [7:0] since_clr_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_clr_q <= 8'hFF;
    else if (volatile_clear_q) since_clr_q <= 8'h00;
    else if (since_clr_q != 8'hFF) since_clr_q <= since_clr_q + 8'h01;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_ea; array_erase_all_q; endsequence
  property p_answer; s_setup |=> pready; endproperty
  property p_slverr; pslverr |-> pready && psel && penable; endproperty
  property p_irq; irq |=> !irq; endproperty
  property p_ops; $onehot0({array_prog_q, array_erase_page_q, array_erase_all_q}); endproperty
  property p_prog; array_prog_q |-> fuses_out_q[array_page_q[8:5]]; endproperty
  property p_erpg; array_erase_page_q |-> fuses_out_q[array_page_q[8:5]]; endproperty
  property p_ea_ok; s_ea |-> fuses_out_q[15:0] == 16'hFFFF && fuses_out_q[19:17] == 3'h7;
  endproperty
  property p_ea_clr; s_ea |-> since_clr_q < 8'd90; endproperty
  property p_ea_ff; s_ea |-> ##[0:80] fuses_out_q == 32'hFFFFFFFF; endproperty
  a_answer: assert property (p_answer) else $error("pready missing after setup");
  a_slverr: assert property (p_slverr) else $error("pslverr outside access");
  a_irq: assert property (p_irq) else $error("irq longer than a cycle");
  a_ops: assert property (p_ops) else $error("two array operations at once");
  a_prog: assert property (p_prog) else $error("program in locked region");
  a_erpg: assert property (p_erpg) else $error("erase in locked region");
  a_ea_ok: assert property (p_ea_ok) else $error("erase-all while protected");
  a_ea_clr: assert property (p_ea_clr) else $error("erase-all without clear");
  a_ea_ff: assert property (p_ea_ff) else $error("fuses not erased");
endmodule // flash_seq_props
bind flash_command_sequencer flash_seq_props props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .irq(irq), .array_prog_q(array_prog_q),
  .array_erase_page_q(array_erase_page_q), .array_erase_all_q(array_erase_all_q),
  .volatile_clear_q(volatile_clear_q), .array_page_q(array_page_q),
  .fuses_out_q(fuses_out_q));

/* sim/hsb_master_model.sv */
// High-speed bus master model for page buffer writes
`timescale 1ns/1ps
module hsb_master_model (
  input  wire logic        pclk,
  input  wire logic        hold_busy,
  output logic             hsb_idle,
  output logic             pbuf_wr,
  output logic [20:0]      pbuf_word_addr,
  output logic [31:0]      pbuf_wdata
);
  assign hsb_idle = !hold_busy && !pbuf_wr;
  initial begin
    pbuf_wr = 1'b0;
    pbuf_word_addr = 21'h000000;
    pbuf_wdata = 32'h00000000;
  end
  task automatic buf_write(input logic [20:0] a, input logic [31:0] d);
    @(posedge pclk);
    pbuf_wr <= 1'b1;
    pbuf_word_addr <= a;
    pbuf_wdata <= d;
    @(posedge pclk);
    pbuf_wr <= 1'b0;
    pbuf_word_addr <= ~a;
    pbuf_wdata <= ~d;
  endtask
endmodule // hsb_master_model

/* sim/flash_command_sequencer_tb.sv */
// Self-checking bench of the flash command sequencer
`timescale 1ns/1ps
`include "flash_seq_params.svh"
module flash_command_sequencer_tb;
  logic        pclk, presetn, psel, penable, pwrite, hold_busy, err, pready, pslverr, irq;
  logic        hsb_idle, pbuf_wr, array_prog_q, array_erase_page_q, array_erase_all_q;
  logic        volatile_clear_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, st, s, pbuf_wdata, fuses_out_q;
  logic [20:0] pbuf_word_addr;
  logic [9:0]  array_page_q;
  int          fail_count, cmp_count, wp_n, ep_n, ea_n, vc_n, irq_n, n0;
  flash_command_sequencer flash_command_sequencer_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hsb_idle(hsb_idle),
    .pbuf_wr(pbuf_wr), .pbuf_word_addr(pbuf_word_addr), .pbuf_wdata(pbuf_wdata), .irq(irq),
    .array_prog_q(array_prog_q), .array_erase_page_q(array_erase_page_q),
    .array_erase_all_q(array_erase_all_q), .volatile_clear_q(volatile_clear_q),
    .array_page_q(array_page_q), .fuses_out_q(fuses_out_q));
  hsb_master_model hsb_master_model_inst (.pclk(pclk), .hold_busy(hold_busy),
    .hsb_idle(hsb_idle), .pbuf_wr(pbuf_wr), .pbuf_word_addr(pbuf_word_addr),
    .pbuf_wdata(pbuf_wdata));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    wp_n += array_prog_q;
    ep_n += array_erase_page_q;
    ea_n += array_erase_all_q;
    vc_n += volatile_clear_q;
    irq_n += irq;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      stop_test();
    end
    st = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] k, input logic [9:0] pg, input logic [5:0] c);
    apb(1'b1, `FS_ADDR_CMD, {k, 6'h00, pg, 2'h0, c});
  endtask
  task automatic wait_rdy();
    int n;
    s = 32'h0;
    for (n = 0; n < 100; n++) begin
      apb(1'b0, `FS_ADDR_STATUS, 32'h0);
      s = s | st;
      if (st[0] === 1'b1) break;
    end
    if (n == 100) begin
      fail_count++;
      stop_test();
    end
  endtask
  task automatic run(input logic [9:0] pg, input logic [5:0] c);
    cmd(`FS_KEY_DEFAULT, pg, c);
    wait_rdy();
  endtask
  task automatic t_reset();
    apb(1'b0, `FS_ADDR_STATUS, 32'h0);
    chk(st[0], 1'b1);
    apb(1'b0, `FS_ADDR_FUSE, 32'h0);
    chk(st, `FS_FUSE_RESET);
    apb(1'b1, 12'h010, 32'h1);
    chk(err, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    chk({err, st[30:0]}, 32'h80000000);
  endtask
  task automatic t_refused();
    n0 = ep_n;
    cmd(8'h5A, 10'h0, `FS_CMD_EP);
    wait_rdy();
    chk(s[3], 1'b1);
    cmd(`FS_KEY_DEFAULT, 10'h0, 6'h3F);
    wait_rdy();
    chk(s[3], 1'b1);
    apb(1'b0, `FS_ADDR_STATUS, 32'h0);
    chk(st[3:2], 2'h0);
    chk(ep_n, n0);
  endtask
  task automatic t_program();
    run(10'h0, `FS_CMD_CPB);
    hsb_master_model_inst.buf_write(21'd130, 32'h12345678);
    apb(1'b0, `FS_ADDR_CMD, 32'h0);
    chk(st[17:8], 10'h001);
    n0 = wp_n;
    hold_busy <= 1'b1;
    cmd(`FS_KEY_DEFAULT, 10'h001, `FS_CMD_WP);
    apb(1'b0, `FS_ADDR_STATUS, 32'h0);
    chk(st[0], 1'b0);
    repeat (10) @(posedge pclk);
    chk(wp_n, n0);
    hold_busy <= 1'b0;
    wait_rdy();
    chk(wp_n, n0 + 1);
    chk(array_page_q, 10'h001);
  endtask
  task automatic t_busy();
    n0 = ep_n;
    cmd(`FS_KEY_DEFAULT, 10'h003, `FS_CMD_EP);
    cmd(`FS_KEY_DEFAULT, 10'h003, `FS_CMD_EP);
    wait_rdy();
    chk(s[3], 1'b1);
    chk(ep_n, n0 + 1);
  endtask
  task automatic t_irq_check();
    apb(1'b1, `FS_ADDR_CTRL, 32'h1);
    n0 = irq_n;
    run(10'h0, `FS_CMD_CPB);
    chk(irq_n, n0 + 1);
    run(10'h0, `FS_CMD_CHK);
    chk({irq_n == n0 + 1, st[5]}, 2'b11);
    hsb_master_model_inst.buf_write(21'd5, 32'h0);
    hsb_master_model_inst.buf_write(21'd5, 32'hFFFFFFFF);
    run(10'h0, `FS_CMD_CHK);
    chk(st[5], 1'b0);
  endtask
  task automatic t_lock();
    apb(1'b1, `FS_ADDR_CTRL, 32'h4);
    run(10'h040, `FS_CMD_LOCK);
    chk(fuses_out_q, 32'hFFFFFFFB);
    n0 = irq_n;
    run(10'h05F, `FS_CMD_EP);
    chk({s[2], irq_n != n0}, 2'b11);
    n0 = ep_n;
    run(10'h060, `FS_CMD_EP);
    chk(ep_n, n0 + 1);
    n0 = ea_n;
    run(10'h0, `FS_CMD_EA);
    chk({s[2], ea_n == n0}, 2'b11);
    run(10'h05F, `FS_CMD_UNLOCK);
    chk(fuses_out_q, `FS_FUSE_RESET);
    vc_n = 0;
    run(10'h0, `FS_CMD_EA);
    chk({s[3:2], ea_n == n0 + 1, vc_n > 0}, 4'h3);
    chk(fuses_out_q, `FS_FUSE_RESET);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, hold_busy} = 5'h00;
    {paddr, pwdata} = 44'h0;
    fail_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_refused();
    t_program();
    t_busy();
    t_irq_check();
    t_lock();
    stop_test();
  end
endmodule // flash_command_sequencer_tb
